/* hdl/pgmb_defines.svh */
// offsets, field positions and timing constants of the power-good mask bank
`ifndef PGMB_DEFINES_SVH
`define PGMB_DEFINES_SVH

// register byte offsets on the serial control port
`define PGMB_OUT4_MASK_LOW_ADDR  8'hA6
`define PGMB_OUT4_MASK_HIGH_ADDR 8'hA7
`define PGMB_OUT2_MASK_LOW_ADDR  8'hA8
`define PGMB_OUT2_MASK_HIGH_ADDR 8'hA9

// register indices within the bank
`define PGMB_IDX_OUT4_LOW  2'h0
`define PGMB_IDX_OUT4_HIGH 2'h1
`define PGMB_IDX_OUT2_LOW  2'h2
`define PGMB_IDX_OUT2_HIGH 2'h3

// low mask register fields
`define PGMB_LINEAR_TWO_BIT   7
`define PGMB_SWITCH_A_ONE_BIT 6
`define PGMB_STEPDOWN_MSB     5
`define PGMB_STEPDOWN_LSB     0

// high mask register fields
`define PGMB_CTRL_FIVE_BIT    7
`define PGMB_CTRL_FOUR_BIT    6
`define PGMB_CTRL_TWO_BIT     5
`define PGMB_CTRL_ONE_BIT     4
`define PGMB_TERMINATION_BIT  3
`define PGMB_SHARED_SLOT_BIT  2
`define PGMB_SWITCH_B_ONE_BIT 1
`define PGMB_LINEAR_THREE_BIT 0

// value read back from an unmapped offset
`define PGMB_UNMAPPED_DATA 8'h00

// mask value held while reset is asserted: every source ignored
`define PGMB_MASK_RESET 8'hFF

// cycles from source change to combined output
`define PGMB_TREE_LATENCY 1

`endif

/* hdl/pgmb_pkg.sv */
// types of the power-good mask bank
package pgmb_pkg;

  // raw power-good flags and control-pin states
  typedef struct packed {
    logic [5:0] stepdown_good;
    logic       switch_a_one_good;
    logic       linear_two_good;
    logic       linear_three_good;
    logic       switch_b_one_good;
    logic       switch_b_two_good;
    logic       linear_one_good;
    logic       termination_good;
    logic       ctrl_pin_one;
    logic       ctrl_pin_two;
    logic       ctrl_pin_four;
    logic       ctrl_pin_five;
  } pgmb_sources_t;

  // one pin's pair of mask registers
  typedef struct packed {
    logic [7:0] mask_high;
    logic [7:0] mask_low;
  } pgmb_mask_pair_t;

  // factory configuration: defaults of all four registers and the slot variant
  typedef struct packed {
    pgmb_mask_pair_t out4;
    pgmb_mask_pair_t out2;
    logic            slot_is_switch;
  } pgmb_factory_t;

endpackage

/* hdl/pgmb_mask_bank.sv */
// power-good mask bank for general outputs four and two
// Summary of operation
// - out4_mask_high at A7h, eight bits read-write
// - high bits 7..4 mask control pins 5,4,2,1
// - high bits 3..0 mask termination, slot, switch, linear
// - a set mask bit removes its source
// - slot bit selects switch or linear per variant
// - out2_mask_low at A8h, eight bits read-write
// - low bit 7 linear two, 6 switch one
// - low bits 5..0 mask step-down rails six..one
// - out2_mask_high at A9h, same layout as A7h
// - defaults loaded from factory configuration
// - out4_mask_low at A6h, same layout as A8h
`timescale 1ns/1ps
`include "pgmb_defines.svh"

module pgmb_mask_bank (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset_n,
  input  wire pgmb_pkg::pgmb_factory_t i_factory_cfg,
  input  wire pgmb_pkg::pgmb_sources_t i_sources,
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic [7:0]             i_reg_wdata,
  input  wire logic                   i_reg_rd,
  output logic [7:0]                  o_reg_rdata,
  output logic                        o_out4_good,
  output logic                        o_out2_good
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] mask_reg [4];
  logic       defaults_loaded;
  logic       slot_is_switch;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic       addr_hit;
  logic [1:0] addr_idx;
  logic [7:0] addr_off;
  logic       write_hit;
  logic [7:0] read_data;
  logic       shared_good;

  // the bank occupies A6h..A9h contiguously
  assign addr_off  = i_reg_addr - `PGMB_OUT4_MASK_LOW_ADDR;
  assign addr_hit  = (i_reg_addr >= `PGMB_OUT4_MASK_LOW_ADDR) &&
                     (i_reg_addr <= `PGMB_OUT2_MASK_HIGH_ADDR);
  assign addr_idx  = addr_off[1:0];
  assign write_hit = i_reg_wr && addr_hit && defaults_loaded;
  assign read_data = addr_hit ? mask_reg[addr_idx] : `PGMB_UNMAPPED_DATA;

  // ----------------------------------------------------------------
  // default load: constants under reset, factory values at release
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      defaults_loaded <= 1'b0;
      slot_is_switch  <= 1'b0;
    end else if (!defaults_loaded) begin
      defaults_loaded <= 1'b1;
      slot_is_switch  <= i_factory_cfg.slot_is_switch;
    end
  end

  // register storage; all bits fully read-write once defaults are in
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 4; i++) begin
        mask_reg[i] <= `PGMB_MASK_RESET;
      end
    end else if (!defaults_loaded) begin
      mask_reg[`PGMB_IDX_OUT4_LOW]  <= i_factory_cfg.out4.mask_low;
      mask_reg[`PGMB_IDX_OUT4_HIGH] <= i_factory_cfg.out4.mask_high;
      mask_reg[`PGMB_IDX_OUT2_LOW]  <= i_factory_cfg.out2.mask_low;
      mask_reg[`PGMB_IDX_OUT2_HIGH] <= i_factory_cfg.out2.mask_high;
    end else if (write_hit) begin
      mask_reg[addr_idx] <= i_reg_wdata;
    end
  end

  // read data registered on a read strobe
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= read_data;
    end
  end

  // ----------------------------------------------------------------
  // source vectors in register bit order
  // ----------------------------------------------------------------
  logic [7:0] src_low;
  logic [7:0] src_high;

  assign shared_good = slot_is_switch ? i_sources.switch_b_two_good
                                      : i_sources.linear_one_good;

  // low byte: linear two, switch a one, step-down six..one
  assign src_low[`PGMB_LINEAR_TWO_BIT]                      = i_sources.linear_two_good;
  assign src_low[`PGMB_SWITCH_A_ONE_BIT]                    = i_sources.switch_a_one_good;
  assign src_low[`PGMB_STEPDOWN_MSB:`PGMB_STEPDOWN_LSB]     = i_sources.stepdown_good;

  // high byte: control pins then regulator flags
  assign src_high[`PGMB_CTRL_FIVE_BIT]    = i_sources.ctrl_pin_five;
  assign src_high[`PGMB_CTRL_FOUR_BIT]    = i_sources.ctrl_pin_four;
  assign src_high[`PGMB_CTRL_TWO_BIT]     = i_sources.ctrl_pin_two;
  assign src_high[`PGMB_CTRL_ONE_BIT]     = i_sources.ctrl_pin_one;
  assign src_high[`PGMB_TERMINATION_BIT]  = i_sources.termination_good;
  assign src_high[`PGMB_SHARED_SLOT_BIT]  = shared_good;
  assign src_high[`PGMB_SWITCH_B_ONE_BIT] = i_sources.switch_b_one_good;
  assign src_high[`PGMB_LINEAR_THREE_BIT] = i_sources.linear_three_good;

  // ----------------------------------------------------------------
  // power-good trees, one per output pin
  // ----------------------------------------------------------------
  logic [1:0] tree_good;
  logic [1:0] tree_q;

  // a masked bit forces its term true, so it cannot pull the pin low
  for (genvar p = 0; p < 2; p++) begin : g_tree
    assign tree_good[p] = &({src_high, src_low} | {mask_reg[2*p+1], mask_reg[2*p]});
  end

  // outputs held low until the factory defaults are in place
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tree_q <= 2'h0;
    end else begin
      tree_q <= defaults_loaded ? tree_good : 2'h0;
    end
  end

  assign o_out4_good = tree_q[0];
  assign o_out2_good = tree_q[1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // register port: a write on one edge is seen by a read on the next
  write_read_back_a: assert property (
    (write_hit && i_reg_addr == `PGMB_OUT4_MASK_HIGH_ADDR) ##1
    (i_reg_rd && i_reg_addr == `PGMB_OUT4_MASK_HIGH_ADDR && !i_reg_wr)
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("out4 high mask did not read back the written value");

  out4_high_store_a: assert property (
    write_hit && i_reg_addr == `PGMB_OUT4_MASK_HIGH_ADDR
    |=> mask_reg[`PGMB_IDX_OUT4_HIGH] == $past(i_reg_wdata))
    else $error("out4 high mask write lost");

  out2_low_store_a: assert property (
    write_hit && i_reg_addr == `PGMB_OUT2_MASK_LOW_ADDR
    |=> mask_reg[`PGMB_IDX_OUT2_LOW] == $past(i_reg_wdata))
    else $error("out2 low mask write lost");

  out2_high_store_a: assert property (
    write_hit && i_reg_addr == `PGMB_OUT2_MASK_HIGH_ADDR
    |=> mask_reg[`PGMB_IDX_OUT2_HIGH] == $past(i_reg_wdata))
    else $error("out2 high mask write lost");

  out4_low_store_a: assert property (
    write_hit && i_reg_addr == `PGMB_OUT4_MASK_LOW_ADDR
    |=> mask_reg[`PGMB_IDX_OUT4_LOW] == $past(i_reg_wdata))
    else $error("out4 low mask write lost");

  // offsets outside the bank read back as the unmapped value
  unmapped_read_a: assert property (
    i_reg_rd && (i_reg_addr < `PGMB_OUT4_MASK_LOW_ADDR || i_reg_addr > `PGMB_OUT2_MASK_HIGH_ADDR)
    |=> o_reg_rdata == `PGMB_UNMAPPED_DATA)
    else $error("unmapped offset did not read back zero");

  // every register and the slot variant come from the factory image
  default_load_a: assert property (
    $rose(defaults_loaded) |->
      mask_reg[`PGMB_IDX_OUT4_LOW] == $past(i_factory_cfg.out4.mask_low) &&
      mask_reg[`PGMB_IDX_OUT4_HIGH] == $past(i_factory_cfg.out4.mask_high) &&
      mask_reg[`PGMB_IDX_OUT2_LOW] == $past(i_factory_cfg.out2.mask_low) &&
      mask_reg[`PGMB_IDX_OUT2_HIGH] == $past(i_factory_cfg.out2.mask_high) &&
      slot_is_switch == $past(i_factory_cfg.slot_is_switch))
    else $error("factory defaults not loaded at reset release");

  // trees and their masks
  masked_ctrl_ignored_a: assert property (
    defaults_loaded && mask_reg[`PGMB_IDX_OUT4_HIGH] == 8'hFF && mask_reg[`PGMB_IDX_OUT4_LOW] == 8'hFF
    |=> o_out4_good)
    else $error("fully masked out4 tree not good");

  ctrl_unmasked_low_a: assert property (
    defaults_loaded && !mask_reg[`PGMB_IDX_OUT2_HIGH][`PGMB_CTRL_FIVE_BIT] && !i_sources.ctrl_pin_five
    |=> !o_out2_good)
    else $error("unmasked low control pin five did not drop out2");

  term_unmasked_low_a: assert property (
    defaults_loaded && !mask_reg[`PGMB_IDX_OUT4_HIGH][`PGMB_TERMINATION_BIT] && !i_sources.termination_good
    |=> !o_out4_good)
    else $error("unmasked termination fault did not drop out4");

  slot_select_a: assert property (
    defaults_loaded && slot_is_switch |-> shared_good == i_sources.switch_b_two_good)
    else $error("shared slot not taken from switch b two");

  slot_linear_a: assert property (
    defaults_loaded && !slot_is_switch && !mask_reg[`PGMB_IDX_OUT4_HIGH][`PGMB_SHARED_SLOT_BIT] &&
    !i_sources.linear_one_good |=> !o_out4_good)
    else $error("unmasked linear one fault did not drop out4");

  stepdown_low_a: assert property (
    defaults_loaded && !mask_reg[`PGMB_IDX_OUT2_LOW][0] && !i_sources.stepdown_good[0]
    |=> !o_out2_good)
    else $error("unmasked step-down one fault did not drop out2");

  linear_two_low_a: assert property (
    defaults_loaded && !mask_reg[`PGMB_IDX_OUT2_LOW][`PGMB_LINEAR_TWO_BIT] && !i_sources.linear_two_good
    |=> !o_out2_good)
    else $error("unmasked linear two fault did not drop out2");

  tree_follows_a: assert property (
    defaults_loaded |=> o_out4_good == $past(tree_good[0]) && o_out2_good == $past(tree_good[1]))
    else $error("combined output does not follow the tree");

  outputs_held_low_a: assert property (
    !defaults_loaded |=> !o_out4_good && !o_out2_good)
    else $error("combined output raised before defaults were loaded");

  // main scenarios
  cover_write_c:  cover property (write_hit ##1 i_reg_rd);
  cover_out4_c:   cover property ($fell(o_out4_good));
  cover_out2_c:   cover property ($rose(o_out2_good));
  cover_switch_c: cover property (defaults_loaded && slot_is_switch);
  cover_masked_c: cover property (defaults_loaded && mask_reg[`PGMB_IDX_OUT4_HIGH] == 8'hFF && o_out4_good);

endmodule

/* dv/pgmb_rail_model.sv */
// model of the regulators and control pins that feed the mask bank
`timescale 1ns/1ps

module pgmb_rail_model (
  input  wire logic [$bits(pgmb_pkg::pgmb_sources_t)-1:0] i_fail,
  output pgmb_pkg::pgmb_sources_t                         o_sources
);
  // ----------------------------------------------------------------
  // rail status
  // ----------------------------------------------------------------
  // every rail reports good unless the bench tells it to fail
  assign o_sources = pgmb_pkg::pgmb_sources_t'(~i_fail);
endmodule

/* dv/testbench.sv */
// self-checking testbench of the power-good mask bank
`timescale 1ns/1ps
`include "pgmb_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench;
  logic                    i_mclk, i_reset_n, i_reg_wr, i_reg_rd, o_out4_good, o_out2_good;
  logic [7:0]              i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [7:0]              addrs [4];
  logic [7:0]              dflt [4];
  logic [15:0]             m;
  logic [16:0]             fail;
  pgmb_pkg::pgmb_factory_t cfg;
  pgmb_pkg::pgmb_sources_t src;
  int                      bad_count, checks;

  pgmb_mask_bank dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_factory_cfg(cfg), .i_sources(src),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_out4_good(o_out4_good), .o_out2_good(o_out2_good));
  pgmb_rail_model rail_u (.i_fail(fail), .o_sources(src));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected tree: masks are {high, low}, a set bit drops its source
  function automatic logic good(input pgmb_pkg::pgmb_sources_t s, input logic [15:0] mk, input logic sw);
    logic [7:0] lo, hi;
    lo = {s.linear_two_good, s.switch_a_one_good, s.stepdown_good};
    hi = {s.ctrl_pin_five, s.ctrl_pin_four, s.ctrl_pin_two, s.ctrl_pin_one, s.termination_good,
          sw ? s.switch_b_two_good : s.linear_one_good, s.switch_b_one_good, s.linear_three_good};
    return &(lo | mk[7:0]) & &(hi | mk[15:8]);
  endfunction

  task automatic conclude;
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr    <= 1'b0;
  endtask

  // write then read the same offset on the very next edge
  task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr    <= 1'b0;
    i_reg_rd    <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd    <= 1'b0;
    #1;
    `CHK(o_reg_rdata, d)
  endtask

  // read strobe for one cycle, data compared after the taking edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd   <= 1'b0;
    #1;
    `CHK(o_reg_rdata, exp)
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (100000) @(posedge i_mclk);
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence: one pass per slot variant
  // ----------------------------------------------------------------
  initial begin
    i_reset_n = 1'b0; i_reg_wr = 1'b0; i_reg_rd = 1'b0; i_reg_addr = 8'h00; i_reg_wdata = 8'h00;
    fail = '0; cfg = '0; bad_count = 0; checks = 0;
    addrs = '{`PGMB_OUT4_MASK_LOW_ADDR, `PGMB_OUT4_MASK_HIGH_ADDR, `PGMB_OUT2_MASK_LOW_ADDR,
              `PGMB_OUT2_MASK_HIGH_ADDR};
    for (int v = 0; v < 2; v++) begin
      // reset with a fresh factory image, also a second reset in mid-run
      @(posedge i_mclk);
      i_reset_n <= 1'b0;
      cfg       <= v ? {16'h7FBF, 16'hFCC0, 1'b1} : {16'hBFF7, 16'h3FDF, 1'b0};
      repeat (20) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      dflt = '{cfg.out4.mask_low, cfg.out4.mask_high, cfg.out2.mask_low, cfg.out2.mask_high};
      for (int i = 0; i < 4; i++)
        rd_chk(addrs[i], dflt[i]);
      // each source failing alone (17 = none) against each single mask bit (16 = none)
      for (int k = 0; k < 18; k++) begin
        @(posedge i_mclk);
        fail <= (k < 17) ? (17'h1 << k) : 17'h0;
        for (int j = 0; j < 17; j++) begin
          m = (j < 16) ? (16'h1 << j) : 16'h0;
          wr(`PGMB_OUT4_MASK_LOW_ADDR, m[7:0]);
          wr(`PGMB_OUT4_MASK_HIGH_ADDR, m[15:8]);
          wr(`PGMB_OUT2_MASK_LOW_ADDR, m[15:8]);
          wr(`PGMB_OUT2_MASK_HIGH_ADDR, m[7:0]);
          repeat (2) @(posedge i_mclk);
          #1;
          `CHK(o_out4_good, good(src, m, cfg.slot_is_switch))
          `CHK(o_out2_good, good(src, {m[7:0], m[15:8]}, cfg.slot_is_switch))
        end
      end
    end
    // writes on alternate edges, then read all back
    for (int i = 0; i < 4; i++)
      wr(addrs[i], 8'h5A ^ (8'h11 << i));
    wr(8'hAA, 8'hFF);
    for (int i = 0; i < 4; i++)
      rd_chk(addrs[i], 8'h5A ^ (8'h11 << i));
    rd_chk(8'hAA, `PGMB_UNMAPPED_DATA);
    rd_chk(8'hA5, `PGMB_UNMAPPED_DATA);
    // every source failing, every mask set: both pins still read good
    @(posedge i_mclk);
    fail <= '1;
    for (int i = 0; i < 4; i++)
      wr(addrs[i], 8'hFF);
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK(o_out4_good, 1'b1)
    `CHK(o_out2_good, 1'b1)
    // unmask control pin five of out4 and read it back on the next edge
    wr_rd_chk(`PGMB_OUT4_MASK_HIGH_ADDR, 8'h7F);
    `CHK(o_out4_good, 1'b0)
    `CHK(o_out2_good, 1'b1)
    repeat (2) @(posedge i_mclk);
    conclude();
  end
endmodule
